// >>> design/slc_defs.svh
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH

// Register addresses on the serial register port
`define SLC_ADDR_TS_CTRL 15'h0160
`define SLC_ADDR_LINK_EN 15'h0200
`define SLC_ADDR_MODE 15'h0201
`define SLC_ADDR_KM1 15'h0202
`define SLC_ADDR_SYNC 15'h0203

// Field positions
`define SLC_BIT_ENABLE 0
`define SLC_MODE_MSB 5

// Reset values
`define SLC_RST_TS_EN 1'b0
`define SLC_RST_LINK_EN 1'b1
`define SLC_RST_MODE 6'h00
`define SLC_RST_KM1 8'h1F
`define SLC_RST_SYNC 1'b1
`define SLC_ILA_CS 2'h0

// Serial port framing: R/W bit, 15 address bits, 8 data bits
`define SLC_SPI_HDR_LAST 5'h0F
`define SLC_SPI_LAST 5'h17

// Pin synchroniser depth; the sample path is delayed to match
`define SLC_TS_SYNC 2

// Numerator of the 64B/66B effective K
`define SLC_K66_NUM 256

`endif

// >>> design/slc_pkg.sv
package slc_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [14:0] reg_addr_t;
  typedef enum logic [1:0] {
    SP_HDR,
    SP_WR,
    SP_RD,
    SP_DONE
  } spi_phase_e;
endpackage

// >>> design/lat_delay.sv
`timescale 1ns/100ps
`default_nettype none

module lat_delay #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  if (DEPTH < 1) begin : g_bad
    $error("lat_delay: DEPTH must be at least 1");
  end

  logic [W-1:0] stage_r [1:DEPTH];
  logic [W-1:0] stage_nxt [1:DEPTH];

  for (genvar i = 1; i <= DEPTH; i++) begin : g_stage
    if (i == 1) begin : g_first
      always_comb begin
        stage_nxt[i] = i_clr ? '0 : i_d;
      end
    end else begin : g_next
      always_comb begin
        stage_nxt[i] = i_clr ? '0 : stage_r[i-1];
      end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        stage_r[i] <= '0;
      end else begin
        stage_r[i] <= stage_nxt[i];
      end
    end
  end

  assign o_q = stage_r[DEPTH];
endmodule // lat_delay

`default_nettype wire

// >>> design/sample_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module sample_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8,
  localparam int PW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 2)
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic [CW-1:0] o_count,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad
    $error("sample_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic ov_r, ov_nxt;
  logic [W-1:0] od_r, od_nxt;
  logic push, pop;

  // Full is the memory count alone; the output register is one extra slot
  assign o_in_ready = (cnt_r != CW'(DEPTH));
  assign push = i_in_valid && o_in_ready && !i_clr;
  assign pop = (cnt_r != '0) && (!ov_r || i_out_ready);

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    ov_nxt = ov_r;
    od_nxt = od_r;
    if (i_clr) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
      ov_nxt = 1'b0;
    end else begin
      if (push) begin
        wp_nxt = wp_r + PW'(1);
      end
      if (pop) begin
        rp_nxt = rp_r + PW'(1);
        ov_nxt = 1'b1;
        od_nxt = mem[rp_r];
      end else if (i_out_ready) begin
        ov_nxt = 1'b0;
      end
      cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end

  assign o_count = cnt_r + CW'(ov_r);
  assign o_out_valid = ov_r;
  assign o_out_data = od_r;
endmodule // sample_fifo

`default_nettype wire

// >>> design/serial_link_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "slc_defs.svh"

// What this block does
// - Timestamp enable set: timestamp rides in the LSB of every sample
// - Timestamp latency through the block equals sample latency
// - Wide link field: control bit at field LSB, converter bits intact
// - Advertised control-bit count in lane alignment data is always 0
// - Link enable bit 0 disables link, 1 enables; resets to 1
// - Link disabled: link held in reset, serializers down, clocks gated
// - Link disabled: multiframe counter held in reset, SYSREF ignored
// - Output mode is a 6-bit field at bits 5:0; upper bits reserved
// - Frames register holds K-1; device uses stored value plus one
// - Frames register resets to 31, giving 32 frames per multiframe
// - 64B/66B modes ignore frames register; K is 256*E/F
// - Sync bit written 0 requests resynchronisation; resets to 1

module serial_link_control_regs
  import slc_pkg::*;
#(
  parameter int ADC_W = 9,
  parameter int LINK_W = 16,
  parameter int FIFO_DEPTH = 8,
  parameter int MF_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  input wire logic i_smp_valid,
  input wire logic [ADC_W-1:0] i_smp_data,
  output logic o_smp_ready,
  input wire logic i_tmstp,
  input wire logic i_sysref,
  input wire logic i_frame_tick,
  input wire logic i_mode_is_66b,
  input wire logic [3:0] i_mode_e,
  input wire logic [7:0] i_mode_f,
  output logic o_link_valid,
  output logic [LINK_W-1:0] o_link_data,
  input wire logic i_link_ready,
  output logic o_link_rst_n,
  output logic o_serdes_pd,
  output logic o_link_clk_en,
  output logic [5:0] o_output_mode,
  output logic [MF_W-1:0] o_k_frames,
  output logic o_mf_boundary,
  output logic o_sync_req,
  output logic [1:0] o_ila_cs
);
  localparam int TS_SYNC = `SLC_TS_SYNC;
  localparam int CW = $clog2(FIFO_DEPTH + 2);
  localparam int RDY_MAX = FIFO_DEPTH - TS_SYNC - 2;

  if (LINK_W < ADC_W || ADC_W < 1 || RDY_MAX < 1 || MF_W < 12) begin : g_bad
    $error("serial_link_control_regs: unsupported parameters");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: cs_n, sclk, sdi, timestamp, sysref
  localparam int P_CS = 0;
  localparam int P_SCK = 1;
  localparam int P_SDI = 2;
  localparam int P_TS = 3;
  localparam int P_SYS = 4;

  logic [4:0] pin_s1_r, pin_s2_r;
  logic sck_d_r, sys_d_r;
  logic sck_rise, sck_fall, sys_rise;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Sclk rests low; a high reset value would fake a fall
      pin_s1_r <= 5'h01;
      pin_s2_r <= 5'h01;
      sck_d_r <= 1'b0;
      sys_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {i_sysref, i_tmstp, i_spi_sdi, i_spi_sclk, i_spi_cs_n};
      pin_s2_r <= pin_s1_r;
      sck_d_r <= pin_s2_r[P_SCK];
      sys_d_r <= pin_s2_r[P_SYS];
    end
  end

  assign sck_rise = pin_s2_r[P_SCK] && !sck_d_r;
  assign sck_fall = !pin_s2_r[P_SCK] && sck_d_r;
  assign sys_rise = pin_s2_r[P_SYS] && !sys_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic ts_en_r, ts_en_nxt;
  logic link_en_r, link_en_nxt;
  logic [5:0] mode_r, mode_nxt;
  logic [7:0] km1_r, km1_nxt;
  logic sync_bit_r, sync_bit_nxt;
  logic wr_r;
  reg_addr_t hdr_addr;
  reg_byte_t wr_data;

  function automatic reg_byte_t rd_mux(input reg_addr_t a);
    reg_byte_t d;
    d = 8'h00;
    unique case (a)
      `SLC_ADDR_TS_CTRL: d[`SLC_BIT_ENABLE] = ts_en_r;
      `SLC_ADDR_LINK_EN: d[`SLC_BIT_ENABLE] = link_en_r;
      `SLC_ADDR_MODE: d[`SLC_MODE_MSB:0] = mode_r;
      `SLC_ADDR_KM1: d = km1_r;
      `SLC_ADDR_SYNC: d[`SLC_BIT_ENABLE] = sync_bit_r;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // No interlock on writes; ordering against link enable is host duty
  always_comb begin
    ts_en_nxt = ts_en_r;
    link_en_nxt = link_en_r;
    mode_nxt = mode_r;
    km1_nxt = km1_r;
    sync_bit_nxt = sync_bit_r;
    if (wr_r) begin
      unique case (hdr_addr)
        `SLC_ADDR_TS_CTRL: ts_en_nxt = wr_data[`SLC_BIT_ENABLE];
        `SLC_ADDR_LINK_EN: link_en_nxt = wr_data[`SLC_BIT_ENABLE];
        `SLC_ADDR_MODE: mode_nxt = wr_data[`SLC_MODE_MSB:0];
        `SLC_ADDR_KM1: km1_nxt = wr_data;
        `SLC_ADDR_SYNC: sync_bit_nxt = wr_data[`SLC_BIT_ENABLE];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ts_en_r <= `SLC_RST_TS_EN;
      link_en_r <= `SLC_RST_LINK_EN;
      mode_r <= `SLC_RST_MODE;
      km1_r <= `SLC_RST_KM1;
      sync_bit_r <= `SLC_RST_SYNC;
    end else begin
      ts_en_r <= ts_en_nxt;
      link_en_r <= link_en_nxt;
      mode_r <= mode_nxt;
      km1_r <= km1_nxt;
      sync_bit_r <= sync_bit_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial register port, mode 0, MSB first
  spi_phase_e ph_r, ph_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] hdr_r, hdr_nxt;
  reg_byte_t dat_r, dat_nxt;
  logic sdo_r, sdo_nxt, oe_r, oe_nxt, wr_nxt;

  assign hdr_addr = hdr_r[14:0];
  assign wr_data = dat_r;

  always_comb begin
    ph_nxt = ph_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    dat_nxt = dat_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    wr_nxt = 1'b0;
    if (pin_s2_r[P_CS]) begin
      ph_nxt = SP_HDR;
      cnt_nxt = '0;
      oe_nxt = 1'b0;
    end else if (sck_rise) begin
      cnt_nxt = cnt_r + 5'h01;
      unique case (ph_r)
        SP_HDR: begin
          hdr_nxt = {hdr_r[14:0], pin_s2_r[P_SDI]};
          if (cnt_r == `SLC_SPI_HDR_LAST) begin
            // Read data is sampled once the last address bit is in
            if (hdr_r[14]) begin
              ph_nxt = SP_RD;
              dat_nxt = rd_mux({hdr_r[13:0], pin_s2_r[P_SDI]});
            end else begin
              ph_nxt = SP_WR;
            end
          end
        end
        SP_WR: begin
          dat_nxt = {dat_r[6:0], pin_s2_r[P_SDI]};
          if (cnt_r == `SLC_SPI_LAST) begin
            ph_nxt = SP_DONE;
            wr_nxt = 1'b1;
          end
        end
        SP_RD: begin
          if (cnt_r == `SLC_SPI_LAST) begin
            ph_nxt = SP_DONE;
          end
        end
        SP_DONE: ;
      endcase
    end else if (sck_fall && ph_r == SP_RD) begin
      sdo_nxt = dat_r[7];
      dat_nxt = {dat_r[6:0], 1'b0};
      oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_r <= SP_HDR;
      cnt_r <= '0;
      hdr_r <= '0;
      dat_r <= '0;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      dat_r <= dat_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      wr_r <= wr_nxt;
    end
  end

  assign o_spi_sdo = sdo_r;
  assign o_spi_sdo_oe = oe_r;

  //////////////////////////////////////////////////////////////////////////////
  // Sample path: delay matches the timestamp pin synchroniser
  logic [ADC_W:0] dly_q;
  logic [LINK_W-1:0] word;
  logic fifo_in_ready;
  logic [CW-1:0] fifo_cnt;
  logic rdy_r, rdy_nxt;

  lat_delay #(
    .W(ADC_W + 1),
    .DEPTH(TS_SYNC)
  ) u_dly (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clr(!link_en_r),
    .i_d({i_smp_valid && rdy_r, i_smp_data}),
    .o_q(dly_q)
  );

  always_comb begin
    word = '0;
    word[LINK_W-1 -: ADC_W] = dly_q[ADC_W-1:0];
    if (ts_en_r) begin
      word[0] = pin_s2_r[P_TS];
    end
  end

  sample_fifo #(
    .W(LINK_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clr(!link_en_r),
    .i_in_valid(dly_q[ADC_W]),
    .i_in_data(word),
    .o_in_ready(fifo_in_ready),
    .o_count(fifo_cnt),
    .o_out_valid(o_link_valid),
    .o_out_data(o_link_data),
    .i_out_ready(i_link_ready)
  );

  // Ready leaves room for samples still inside the delay line
  assign rdy_nxt = link_en_r && fifo_in_ready && (fifo_cnt <= CW'(RDY_MAX));

  //////////////////////////////////////////////////////////////////////////////
  // Link control and multiframe counter
  logic [MF_W-1:0] k_r, k_nxt, mf_r, mf_nxt;
  logic bnd_r, bnd_nxt;
  logic lrst_n_r, pd_r, cken_r, sreq_r;
  logic [1:0] cs_r;
  int k66;

  always_comb begin
    k66 = (`SLC_K66_NUM * int'(i_mode_e)) / ((i_mode_f == 8'h00) ? 1 : int'(i_mode_f));
    if (i_mode_is_66b) begin
      k_nxt = MF_W'(k66);
    end else begin
      k_nxt = MF_W'(km1_r) + MF_W'(1);
    end
    mf_nxt = mf_r;
    bnd_nxt = 1'b0;
    if (!link_en_r) begin
      mf_nxt = '0;
    end else if (sys_rise) begin
      mf_nxt = '0;
    end else if (i_frame_tick) begin
      if (mf_r >= k_r - MF_W'(1)) begin
        mf_nxt = '0;
        bnd_nxt = 1'b1;
      end else begin
        mf_nxt = mf_r + MF_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      k_r <= MF_W'(`SLC_RST_KM1) + MF_W'(1);
      mf_r <= '0;
      bnd_r <= 1'b0;
      rdy_r <= 1'b0;
      lrst_n_r <= 1'b0;
      pd_r <= 1'b1;
      cken_r <= 1'b0;
      sreq_r <= 1'b0;
      cs_r <= `SLC_ILA_CS;
    end else begin
      k_r <= k_nxt;
      mf_r <= mf_nxt;
      bnd_r <= bnd_nxt;
      rdy_r <= rdy_nxt;
      lrst_n_r <= link_en_r;
      pd_r <= !link_en_r;
      cken_r <= link_en_r;
      sreq_r <= !sync_bit_r;
      cs_r <= `SLC_ILA_CS;
    end
  end

  assign o_smp_ready = rdy_r;
  assign o_link_rst_n = lrst_n_r;
  assign o_serdes_pd = pd_r;
  assign o_link_clk_en = cken_r;
  assign o_output_mode = mode_r;
  assign o_k_frames = k_r;
  assign o_mf_boundary = bnd_r;
  assign o_sync_req = sreq_r;
  assign o_ila_cs = cs_r;
endmodule // serial_link_control_regs

`default_nettype wire

// >>> sim/serial_link_control_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none

module serial_link_control_regs_chk #(
  parameter int ADC_W = 9,
  parameter int LINK_W = 16,
  parameter int MF_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_frame_tick,
  input wire logic i_mode_is_66b,
  input wire logic [3:0] i_mode_e,
  input wire logic [7:0] i_mode_f,
  input wire logic o_smp_ready,
  input wire logic o_link_valid,
  input wire logic [LINK_W-1:0] o_link_data,
  input wire logic o_link_rst_n,
  input wire logic o_serdes_pd,
  input wire logic o_link_clk_en,
  input wire logic [5:0] o_output_mode,
  input wire logic [MF_W-1:0] o_k_frames,
  input wire logic o_mf_boundary,
  input wire logic o_sync_req,
  input wire logic [1:0] o_ila_cs
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [MF_W-1:0] k66;
  // F of zero counts as one, so the divide never faults
  always_comb k66 = MF_W'(256 * i_mode_e / (i_mode_f == 8'h00 ? 8'h01 : i_mode_f));
  ////////////////////////////////
  ila_zero_a: assert property (o_ila_cs == 2'h0)
    else $error("control bit count nonzero");
  link_on_a: assert property (o_link_rst_n |-> !o_serdes_pd && o_link_clk_en)
    else $error("enabled link powered down");
  link_off_a: assert property (!o_link_rst_n |-> o_serdes_pd && !o_link_clk_en)
    else $error("disabled link still powered");
  off_idle_a: assert property (!o_link_rst_n && !$past(o_link_rst_n)
    |-> !o_smp_ready && !o_link_valid) else $error("disabled link moves data");
  mf_held_a: assert property (!o_link_rst_n |-> !o_mf_boundary)
    else $error("boundary while disabled");
  mf_tick_a: assert property (o_mf_boundary
    |-> $past(i_frame_tick) || $past(i_frame_tick, 2)) else $error("boundary without tick");
  pad_zero_a: assert property (o_link_valid |-> o_link_data[LINK_W-ADC_W-1:1] == '0)
    else $error("pad bits not zero");
  rst_vals_a: assert property (!$past(i_rst_n)
    |-> o_k_frames == MF_W'(8'h20) && o_output_mode == 6'h00 && !o_sync_req)
    else $error("bad value after reset");
  k66_a: assert property ($past(i_mode_is_66b) && i_mode_is_66b && $stable(i_mode_e)
    && $stable(i_mode_f) |-> o_k_frames == k66) else $error("wrong 66b frame count");
  cover property (o_mf_boundary);
  cover property (o_link_valid && o_smp_ready);
  cover property (o_link_rst_n && !o_smp_ready);
  cover property (o_sync_req);
endmodule // serial_link_control_regs_chk

bind serial_link_control_regs serial_link_control_regs_chk #(
  .ADC_W(ADC_W), .LINK_W(LINK_W), .MF_W(MF_W)) chk (
  .i_clk, .i_rst_n, .i_frame_tick, .i_mode_is_66b, .i_mode_e, .i_mode_f, .o_smp_ready,
  .o_link_valid, .o_link_data, .o_link_rst_n, .o_serdes_pd, .o_link_clk_en, .o_output_mode,
  .o_k_frames, .o_mf_boundary, .o_sync_req, .o_ila_cs);

`default_nettype wire

// >>> sim/link_rx_model.sv
`timescale 1ns/100ps
`default_nettype none

// Stall 0: always ready, 1: random stalls, 2: never ready
module link_rx_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_stall,
  output logic o_ready
);
  int seed = 32'h166F96BE;
  initial o_ready = 1'b0;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= (i_stall == 2'h0) || (i_stall == 2'h1 && 1'($random(seed)));
    end
  end
endmodule // link_rx_model

`default_nettype wire

// >>> sim/tb_serial_link_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "slc_defs.svh"

module tb_serial_link_control_regs;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_spi_cs_n = 1'b1, i_spi_sclk = 1'b0;
  logic i_spi_sdi = 1'b0, i_smp_valid = 1'b0, i_tmstp = 1'b0, i_sysref = 1'b0;
  logic i_frame_tick = 1'b0, i_mode_is_66b = 1'b0, i_link_ready;
  logic [8:0] i_smp_data = 9'h000;
  logic [3:0] i_mode_e = 4'h1;
  logic [7:0] i_mode_f = 8'h01;
  logic o_spi_sdo, o_spi_sdo_oe, o_smp_ready, o_link_valid, o_link_rst_n, o_serdes_pd;
  logic o_link_clk_en, o_mf_boundary, o_sync_req;
  logic [15:0] o_link_data;
  logic [5:0] o_output_mode;
  logic [11:0] o_k_frames;
  logic [1:0] o_ila_cs, stall = 2'h0;
  logic [15:0] expq [$];
  logic [7:0] q;
  int fail_count = 0, n_checks = 0, seed = 32'h166F96BE, mfc = 0;
  localparam logic [14:0] ADR [6] = '{`SLC_ADDR_TS_CTRL, `SLC_ADDR_LINK_EN, `SLC_ADDR_MODE,
    `SLC_ADDR_KM1, `SLC_ADDR_SYNC, 15'h0300};
  localparam logic [7:0] MSK [6] = '{8'h01, 8'h01, 8'h3F, 8'hFF, 8'h01, 8'h00};
  logic [7:0] rm [6] = '{8'h00, 8'h01, 8'h00, 8'h1F, 8'h01, 8'h00};

  serial_link_control_regs #(.ADC_W(9), .LINK_W(16), .FIFO_DEPTH(8), .MF_W(12)) dut (
    .i_clk, .i_rst_n, .i_spi_cs_n, .i_spi_sclk, .i_spi_sdi, .o_spi_sdo, .o_spi_sdo_oe,
    .i_smp_valid, .i_smp_data, .o_smp_ready, .i_tmstp, .i_sysref, .i_frame_tick,
    .i_mode_is_66b, .i_mode_e, .i_mode_f, .o_link_valid, .o_link_data, .i_link_ready,
    .o_link_rst_n, .o_serdes_pd, .o_link_clk_en, .o_output_mode, .o_k_frames,
    .o_mf_boundary, .o_sync_req, .o_ila_cs);
  link_rx_model rx (.i_clk, .i_rst_n, .i_stall(stall), .o_ready(i_link_ready));
  always #2 i_clk = ~i_clk;
  ////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Sclk phases of 5 clocks leave margin over the pin synchroniser
  task automatic spi(input int i, input logic rd, input logic [7:0] d);
    logic [23:0] f;
    f = {rd, ADR[i], d};
    i_spi_cs_n = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      i_spi_sdi = f[b];
      w(5);
      if (b < 8) q[b] = o_spi_sdo;
      if (b == 0) check("sdo enable", 16'(o_spi_sdo_oe), 16'(rd));
      i_spi_sclk = 1'b1;
      w(5);
      i_spi_sclk = 1'b0;
    end
    w(5);
    i_spi_cs_n = 1'b1;
    w(8);
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    spi(i, 1'b0, d & MSK[i]);
    rm[i] = d & MSK[i];
  endtask
  task automatic rd_chk(input int i);
    spi(i, 1'b1, 8'h00);
    check("register", {8'h00, q}, {8'h00, rm[i]});
  endtask
  task automatic outs();
    check("mode", 16'(o_output_mode), 16'(rm[2][5:0]));
    check("k", 16'(o_k_frames), 16'(rm[3]) + 16'h0001);
    check("sync", 16'(o_sync_req), 16'(!rm[4][0]));
    check("link", {o_link_rst_n, o_serdes_pd, o_link_clk_en},
      {rm[1][0], !rm[1][0], rm[1][0]});
    check("ila", 16'(o_ila_cs), 16'h0000);
  endtask
  task automatic stream(input int n, input logic [1:0] st);
    stall = st;
    repeat (n) begin
      i_smp_valid = 1'($random(seed));
      i_smp_data = 9'($random(seed));
      i_tmstp = 1'($random(seed));
      w(1);
    end
    i_smp_valid = 1'b0;
  endtask
  task automatic drain();
    int k = 0;
    while (expq.size() != 0 && k < 200) begin
      w(1);
      k++;
    end
    check("drain", 16'(expq.size()), 16'h0000);
    if (k == 200) complete_run();
  endtask
  // Boundary may land one or two edges after the tick
  task automatic ticks(input int n, input int kk);
    logic b;
    repeat (n) begin
      i_frame_tick = 1'b1;
      w(1);
      i_frame_tick = 1'b0;
      b = o_mf_boundary;
      w(1);
      b = b | o_mf_boundary;
      if (o_link_rst_n) mfc = (mfc + 1) % kk;
      check("boundary", 16'(b), 16'(mfc == 0 && o_link_rst_n));
      w(2);
    end
  endtask
  ////////////////////////////////
  always @(posedge i_clk) begin
    if (i_smp_valid && o_smp_ready) expq.push_back({i_smp_data, 6'h00, i_tmstp & rm[0][0]});
    if (o_link_valid && i_link_ready) begin
      if (expq.size() == 0) check("stray word", 16'(o_link_valid), 16'h0000);
      else check("word", o_link_data, expq.pop_front());
    end
  end
  initial begin
    w(10);
    i_rst_n = 1'b1;
    w(2);
    outs();
    for (int j = 0; j < 6; j++) rd_chk(j);
    stream(60, 2'h1);
    drain();
    wr(1, 8'h00);
    expq.delete();
    outs();
    ticks(3, 4);
    spi(5, 1'b0, 8'hA5);
    rd_chk(5);
    wr(3, 8'hFF);
    outs();
    wr(0, 8'h01);
    wr(2, 8'($random(seed)));
    wr(3, 8'h03);
    wr(4, 8'h00);
    for (int j = 0; j < 5; j++) rd_chk(j);
    outs();
    wr(4, 8'h01);
    wr(1, 8'h01);
    outs();
    ticks(6, 4);
    i_sysref = 1'b1;
    w(6);
    i_sysref = 1'b0;
    w(6);
    mfc = 0;
    ticks(5, 4);
    stream(80, 2'h1);
    drain();
    stream(30, 2'h2);
    check("full", 16'(o_smp_ready), 16'h0000);
    stall = 2'h1;
    drain();
    stream(10, 2'h2);
    wr(1, 8'h00);
    expq.delete();
    wr(1, 8'h01);
    stall = 2'h0;
    w(20);
    for (int j = 0; j < 4; j++) begin
      i_mode_e = 4'($random(seed)) | 4'h1;
      i_mode_f = (j == 0) ? 8'h00 : 8'($random(seed));
      i_mode_is_66b = 1'b1;
      w(3);
      check("k66", 16'(o_k_frames), 16'(256 * i_mode_e / (i_mode_f == 0 ? 1 : i_mode_f)));
    end
    i_mode_is_66b = 1'b0;
    w(3);
    outs();
    complete_run();
  end
endmodule // tb_serial_link_control_regs

`default_nettype wire
